/* verif/eth_tx_descriptor_dma_tb.sv */
// Self-checking testbench for the transmit descriptor DMA.
`timescale 1ns/1ns
`default_nettype none
module eth_tx_descriptor_dma_tb
  import tx_dma_pkg::*;
;
  localparam logic [31:0] U = 32'h80000000;
  localparam logic [31:0] L = 32'h00008000;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, perr;
  logic        mem_ack, mem_err, tx_valid, tx_ready, tx_end, tx_crc_en, tx_bad, saw_bad;
  logic        tx_sent, tx_collision, tx_retry_limit, pause_active, err_en;
  logic [7:0]  paddr, tx_byte;
  logic [6:0]  tx_pad_len;
  logic [3:0]  lat;
  logic [1:0]  mode;
  logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, err_addr, rx_word, q, crc_pad;
  int          n_mismatch, checks_done, cyc, ends;
  eth_tx_desc_dma dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .mem_err, .tx_byte, .tx_valid, .tx_ready, .tx_end, .tx_crc_en, .tx_pad_len, .tx_bad,
    .tx_sent, .tx_collision, .tx_retry_limit, .pause_active);
  tx_mem_model mem_m (.mclk, .rst, .req(mem_req), .we(mem_we), .addr(mem_addr),
    .wdata(mem_wdata), .lat, .err_en, .err_addr, .rdata(mem_rdata), .ack(mem_ack),
    .err(mem_err));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ==========================================================================
  // MAC stand-in: stalls every other cycle and answers each frame end.
  always @(posedge mclk) begin
    cyc++;
    tx_ready <= ~tx_ready;
    tx_sent <= 1'b0;
    tx_collision <= 1'b0;
    tx_retry_limit <= 1'b0;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) rx_word <= {rx_word[23:0], tx_byte};
    if (tx_bad === 1'b1) saw_bad <= 1'b1;
    if (tx_end === 1'b1) begin
      ends++;
      crc_pad <= {24'h0, tx_crc_en, tx_pad_len};
      tx_sent <= (mode == 2'h0);
      tx_collision <= (mode == 2'h1);
      tx_retry_limit <= (mode == 2'h2);
      if (mode == 2'h1) mode <= 2'h0;
    end
    if (cyc == 30000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ==========================================================================
  // Bus cycles and comparisons.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic desc(input int i, input logic [31:0] w1);
    mem_m.mem[64 + 2 * i] = (i == 1 && w1 == 32'h1) ? 32'h204 : 32'h200;
    mem_m.mem[65 + 2 * i] = w1;
  endtask : desc
  // Starts the queue, optionally halts at once, then waits for a quiet bus.
  task automatic run(input logic [1:0] m, input logic hlt);
    int n;
    int k;
    n = 0;
    k = 0;
    mode = m;
    rx_word = 32'h0;
    saw_bad = 1'b0;
    ends = 0;
    apb(1'b1, OFS_TSTAT, 32'h1F);
    apb(1'b1, OFS_NCTRL, 32'h208);
    if (hlt) apb(1'b1, OFS_NCTRL, 32'h408);
    while (k < 8 && n < 600) begin
      @(posedge mclk);
      k = (mem_req === 1'b0) ? k + 1 : 0;
      n++;
    end
    if (n >= 600) n_mismatch++;
  endtask : run
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // ==========================================================================
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, tx_ready} = {1'b1, 43'h0, 1'b0};
    {tx_sent, tx_collision, tx_retry_limit, pause_active, err_en} = 5'h0;
    {mode, lat, err_addr, n_mismatch, checks_done, cyc} = {2'h0, 4'h1, 32'h200, 96'h0};
    mem_m.mem[128] = 32'h44332211;
    mem_m.mem[129] = 32'h88776655;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(OFS_TSTAT, 32'h0);
    desc(0, L | 32'h3);
    desc(1, U);
    apb(1'b1, OFS_TQPTR, 32'h100);
    run(2'h0, 1'b0);
    chk(rx_word, 32'h00112233);
    chk(crc_pad, 32'hB9);
    chk(mem_m.mem[65], U | L | 32'h3);
    rd(OFS_TSTAT, 32'h10);
    rd(OFS_TQPTR, 32'h108);
    $display("test frame done");
    desc(1, 32'h0);
    desc(2, 32'h40018002);
    mem_m.mem[68] = 32'h204;
    run(2'h0, 1'b0);
    chk(rx_word, 32'h5566);
    chk(crc_pad, 32'h0);
    chk(mem_m.mem[67], U);
    chk(mem_m.mem[69], 32'h40018002);
    rd(OFS_TQPTR, 32'h100);
    $display("test chain done");
    desc(0, L | 32'h1);
    run(2'h1, 1'b1);
    chk(rx_word, 32'h1111);
    chk(ends, 2);
    rd(OFS_TSTAT, 32'h0);
    $display("test halt done");
    {lat, err_en} <= {4'h3, 1'b1};
    desc(1, L | 32'h1);
    mem_m.mem[66] = 32'h200;
    desc(2, U);
    run(2'h0, 1'b0);
    chk(mem_m.mem[67], 32'h10008001);
    rd(OFS_TSTAT, 32'h2);
    rd(OFS_TQPTR, 32'h100);
    {lat, err_en} <= {4'h0, 1'b0};
    desc(0, 32'h1);
    desc(1, U);
    run(2'h0, 1'b0);
    chk(saw_bad, 1'b1);
    chk(mem_m.mem[65], 32'h18000001);
    rd(OFS_TSTAT, 32'h6);
    desc(0, L | 32'h1);
    run(2'h2, 1'b0);
    chk(mem_m.mem[65], 32'h20008001);
    rd(OFS_TSTAT, 32'h1);
    $display("test errors done");
    desc(0, L | 32'h1);
    apb(1'b1, OFS_NCFG, 32'h2000);
    pause_active <= 1'b1;
    run(2'h0, 1'b0);
    chk(mem_m.mem[65], L | 32'h1);
    rd(OFS_TSTAT, 32'h8);
    pause_active <= 1'b0;
    run(2'h0, 1'b0);
    chk(mem_m.mem[65], U | L | 32'h1);
    apb(1'b1, OFS_NCTRL, 32'h0);
    rd(OFS_TQPTR, 32'h100);
    apb(1'b1, OFS_TQPTR, 32'h120);
    rd(OFS_TQPTR, 32'h120);
    rd(8'h40, 32'h0);
    chk(perr, 1'b1);
    $display("test control done");
    conclude();
  end
endmodule : eth_tx_descriptor_dma_tb
`default_nettype wire

/* verif/tx_mem_model.sv */
// Behavioural system memory that answers the DMA bus master port.
`timescale 1ns/1ns
`default_nettype none
module tx_mem_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  lat,
  input  wire logic        err_en,
  input  wire logic [31:0] err_addr,
  output logic      [31:0] rdata,
  output logic             ack,
  output logic             err
);
  logic [31:0] mem [0:255];
  logic [3:0]  cnt;
  // Between requests the data lines invert, so a stale word never passes.
  always @(posedge mclk) begin
    ack <= 1'b0;
    err <= 1'b0;
    if (rst) begin
      cnt   <= 4'h0;
      rdata <= 32'h0;
    end else if (req && !ack && !err) begin
      if (cnt < lat) begin
        cnt <= cnt + 4'h1;
      end else begin
        cnt <= 4'h0;
        if (err_en && addr == err_addr) begin
          err <= 1'b1;
        end else begin
          ack <= 1'b1;
          if (we) mem[addr[9:2]] <= wdata;
          else rdata <= mem[addr[9:2]];
        end
      end
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule : tx_mem_model
`default_nettype wire

/* verilog/eth_tx_desc_dma.sv */
// Transmit descriptor DMA: ring walk, buffer fetch, status write-back.
// How it works
// - Buffers hold 0..2047 bytes, zero accepted.
// - Descriptor: word0 address, word1 control/status.
// - Automatic CRC frames padded to 64 bytes.
// - Write status back to first descriptor word1.
// - Fetch only when used clear; set first.
// - Status bits 29 retry, 28 underrun, 27 exhausted.
// - Wrap bit or 1024 descriptors return pointer.
// - Pointer write restarts at new queue start.
// - Transmit disable resets pointer to queue start.
// - Start bit sets go, status bit 3.
// - Go clears on disable, used, pointer, halt, error.
// - Halt waits for current frame to finish.
// - Collision restarts from frame's first buffer.
// - Used bit mid-frame is error, bad FCS.
// - Transmit error resets pointer to queue start.
// - Used at frame start keeps pointer, resumes.
// - No-CRC flag in last buffer suppresses CRC.
// - Bit 15 last buffer, bits 10:0 length.
// - Received pause with pause enable suspends sending.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module eth_tx_desc_dma
  import tx_dma_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [31:0] mem_wdata,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        mem_ack,
  input  wire logic        mem_err,
  output logic      [7:0]  tx_byte,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic             tx_end,
  output logic             tx_crc_en,
  output logic      [6:0]  tx_pad_len,
  output logic             tx_bad,
  input  wire logic        tx_sent,
  input  wire logic        tx_collision,
  input  wire logic        tx_retry_limit,
  input  wire logic        pause_active
);
  // ==========================================================================
  // Engine states
  typedef enum logic [8:0] {
    S_IDLE = 9'h001, S_RD_W1 = 9'h002, S_RD_W0 = 9'h004,
    S_DATA = 9'h008, S_OUT   = 9'h010, S_NEXT  = 9'h020,
    S_WAIT = 9'h040, S_WB    = 9'h080, S_ERR   = 9'h100
  } state_t;

  state_t      st_q, st_d;
  logic        req_q, req_d, we_q, we_d;
  logic [31:0] addr_q, addr_d, wdata_q, wdata_d;
  logic [31:0] baddr_q, baddr_d, fw1_q, fw1_d, faddr_q, faddr_d;
  logic [10:0] len_q, len_d;
  logic        last_q, last_d, nocrc_q, nocrc_d, wrap_q, wrap_d;
  logic        first_q, first_d;
  logic [9:0]  fidx_q, fidx_d;
  logic [7:0]  byte_q, byte_d;
  logic        val_q, val_d, end_q, end_d, crc_q, crc_d, bad_q, bad_d;
  logic [6:0]  pad_q, pad_d;
  logic [2:0]  errb_q, errb_d;
  // Engine events consumed by the register group, the ring pointer and the pad counter.
  logic        e_used_stop, e_err_stop, e_rewind, e_restart, e_adv, e_clr_cnt, e_inc;
  logic [9:0]  idx;
  logic [31:0] desc_addr;
  logic [6:0]  pad_len;

  // Register group.
  logic        txen_q, txen_d, pen_q, pen_d, go_q, go_d;
  logic        s_ret_q, s_ret_d, s_und_q, s_und_d, s_exh_q, s_exh_d, s_usd_q, s_usd_d;
  logic        rdy_q, rdy_d, serr_q, serr_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wr, rd_pend, mapped, qp_wr, dis_wr, halt_wr, start_wr;

  tx_ring_ptr #(
    .RING_LEN (RING_MAX)
  ) u_ring (
    .mclk        (mclk),
    .rst         (rst),
    .load        (qp_wr),
    .base_in     (pwdata),
    .rewind      (e_rewind),
    .restart     (e_restart),
    .restart_idx (fidx_q),
    .advance     (e_adv),
    .wrap        (wrap_q),
    .idx         (idx),
    .desc_addr   (desc_addr)
  );

  tx_pad_count u_pad (
    .mclk    (mclk),
    .rst     (rst),
    .clr     (e_clr_cnt),
    .inc     (e_inc),
    .pad_len (pad_len)
  );

  // ==========================================================================
  // APB slave: one wait state, then data and pready together.
  assign rd_pend  = psel && penable && !rdy_q;
  assign wr       = psel && penable && rdy_q && pwrite && !serr_q;
  assign mapped   = paddr == OFS_NCTRL || paddr == OFS_NCFG ||
                    paddr == OFS_TSTAT || paddr == OFS_TQPTR;
  assign qp_wr    = wr && paddr == OFS_TQPTR;
  assign dis_wr   = wr && paddr == OFS_NCTRL && !pwdata[NC_TXEN];
  assign halt_wr  = wr && paddr == OFS_NCTRL && pwdata[NC_HALT];
  assign start_wr = wr && paddr == OFS_NCTRL && pwdata[NC_START] && pwdata[NC_TXEN];

  always_comb begin
    txen_d  = txen_q;
    pen_d   = pen_q;
    rdy_d   = rd_pend;
    serr_d  = rd_pend && !mapped;
    rdata_d = RST_WORD;
    if (rd_pend && !pwrite) begin
      unique case (paddr)
        OFS_NCTRL: rdata_d[NC_TXEN]     = txen_q;
        OFS_NCFG:  rdata_d[CF_PAUSE_EN] = pen_q;
        OFS_TSTAT: rdata_d = {27'h0000000, s_usd_q, go_q, s_exh_q, s_und_q, s_ret_q};
        OFS_TQPTR: rdata_d = desc_addr;
        default:   rdata_d = RST_WORD;
      endcase
    end
    if (wr && paddr == OFS_NCTRL) txen_d = pwdata[NC_TXEN];
    if (wr && paddr == OFS_NCFG) pen_d = pwdata[CF_PAUSE_EN];
    // Clearing events beat a start in the same cycle; halt only stops new frames.
    if (dis_wr || qp_wr || halt_wr || e_used_stop || e_err_stop) go_d = 1'b0;
    else if (start_wr) go_d = 1'b1;
    else go_d = go_q;
    // Sticky status: hardware set wins over a write-one clear.
    s_ret_d = (s_ret_q && !(wr && paddr == OFS_TSTAT && pwdata[TS_RETRY])) ||
              (e_err_stop && errb_q[2]);
    s_und_d = (s_und_q && !(wr && paddr == OFS_TSTAT && pwdata[TS_UNDER])) ||
              (e_err_stop && errb_q[1]);
    s_exh_d = (s_exh_q && !(wr && paddr == OFS_TSTAT && pwdata[TS_EXH])) ||
              (e_err_stop && errb_q[0]);
    s_usd_d = (s_usd_q && !(wr && paddr == OFS_TSTAT && pwdata[TS_USED])) || e_used_stop;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      txen_q <= 1'b0; pen_q <= 1'b0; go_q <= 1'b0; rdy_q <= 1'b0; serr_q <= 1'b0;
      s_ret_q <= 1'b0; s_und_q <= 1'b0; s_exh_q <= 1'b0; s_usd_q <= 1'b0;
      rdata_q <= RST_WORD;
    end else begin
      txen_q <= txen_d; pen_q <= pen_d; go_q <= go_d; rdy_q <= rdy_d; serr_q <= serr_d;
      s_ret_q <= s_ret_d; s_und_q <= s_und_d; s_exh_q <= s_exh_d; s_usd_q <= s_usd_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // Descriptor engine
  always_comb begin
    st_d = st_q; req_d = req_q; we_d = we_q; addr_d = addr_q; wdata_d = wdata_q;
    baddr_d = baddr_q; fw1_d = fw1_q; faddr_d = faddr_q; len_d = len_q;
    last_d = last_q; nocrc_d = nocrc_q; wrap_d = wrap_q; first_d = first_q;
    fidx_d = fidx_q; byte_d = byte_q; val_d = val_q; errb_d = errb_q;
    end_d = 1'b0; crc_d = crc_q; pad_d = pad_q; bad_d = bad_q;
    e_used_stop = 1'b0; e_err_stop = 1'b0; e_rewind = 1'b0; e_restart = 1'b0;
    e_adv = 1'b0; e_clr_cnt = 1'b0; e_inc = 1'b0;
    unique case (st_q)
      S_IDLE: begin
        bad_d = 1'b0;
        // A received pause holds off the next frame only.
        if (go_q && txen_q && !(pen_q && pause_active)) begin
          st_d = S_RD_W1; req_d = 1'b1; we_d = 1'b0;
          addr_d = desc_addr + W1_OFS; first_d = 1'b1;
          fidx_d = idx; faddr_d = desc_addr; errb_d = 3'h0; e_clr_cnt = 1'b1;
        end
      end
      S_RD_W1: if (mem_ack || mem_err) begin
        req_d = 1'b0;
        if (mem_err) begin
          st_d = S_ERR; errb_d = 3'b010;
        end else if (mem_rdata[D_USED] && first_q) begin
          st_d = S_IDLE; e_used_stop = 1'b1;
        end else if (mem_rdata[D_USED]) begin
          st_d = S_ERR; errb_d = 3'b011;
        end else begin
          // Word one carries length, last flag, no-CRC and wrap.
          len_d = mem_rdata[D_LEN_MSB:0]; last_d = mem_rdata[D_LAST];
          nocrc_d = mem_rdata[D_NOCRC]; wrap_d = mem_rdata[D_WRAP];
          if (first_q) fw1_d = mem_rdata;
          st_d = S_RD_W0; req_d = 1'b1; addr_d = addr_q - W1_OFS;
        end
      end
      S_RD_W0: if (mem_ack || mem_err) begin
        req_d = 1'b0; baddr_d = mem_rdata;
        if (mem_err) begin
          st_d = S_ERR; errb_d = 3'b010;
        end else if (len_q == 11'h000) begin
          st_d = S_NEXT;
        end else begin
          st_d = S_DATA; req_d = 1'b1; addr_d = {mem_rdata[31:2], 2'b00};
        end
      end
      S_DATA: if (mem_ack || mem_err) begin
        req_d = 1'b0;
        if (mem_err) begin
          st_d = S_ERR; errb_d = 3'b010;
        end else begin
          byte_d = mem_rdata[{baddr_q[1:0], 3'b000} +: 8]; val_d = 1'b1; st_d = S_OUT;
        end
      end
      S_OUT: if (tx_ready) begin
        val_d = 1'b0; e_inc = 1'b1; len_d = len_q - 11'h001;
        baddr_d = baddr_q + 32'h0000_0001;
        if (len_q == 11'h001) st_d = S_NEXT;
        else begin
          st_d = S_DATA; req_d = 1'b1; addr_d = {baddr_d[31:2], 2'b00};
        end
      end
      S_NEXT: begin
        e_adv = 1'b1; first_d = 1'b0;
        if (last_q) begin
          st_d = S_WAIT; end_d = 1'b1; crc_d = !nocrc_q;
          pad_d = nocrc_q ? 7'h00 : pad_len;
        end else if (wrap_q || idx == 10'(RING_MAX - 1)) begin
          // The index only steps at this edge, so the next slot is addressed ahead of it.
          st_d = S_RD_W1; req_d = 1'b1; addr_d = desc_addr - {19'h00000, idx, 3'h0} + W1_OFS;
        end else begin
          st_d = S_RD_W1; req_d = 1'b1; addr_d = desc_addr + DESC_BYTES + W1_OFS;
        end
      end
      S_WAIT: begin
        if (tx_retry_limit) begin
          st_d = S_ERR; errb_d = 3'b100;
        end else if (tx_collision) begin
          // Replay the whole frame from its first buffer.
          e_restart = 1'b1; first_d = 1'b1; e_clr_cnt = 1'b1;
          st_d = S_RD_W1; req_d = 1'b1; addr_d = faddr_q + W1_OFS;
        end else if (tx_sent) begin
          st_d = S_WB; req_d = 1'b1; we_d = 1'b1; addr_d = faddr_q + W1_OFS;
          wdata_d = fw1_q; wdata_d[D_USED] = 1'b1;
          wdata_d[D_RETRY:D_EXH] = 3'h0;
        end
      end
      S_ERR: begin
        bad_d = 1'b1;
        if (!req_q && !we_q) begin
          req_d = 1'b1; we_d = 1'b1; addr_d = faddr_q + W1_OFS;
          wdata_d = fw1_q; wdata_d[D_RETRY:D_EXH] = errb_q;
        end else if (mem_ack || mem_err) begin
          req_d = 1'b0; we_d = 1'b0; st_d = S_IDLE;
          e_err_stop = 1'b1; e_rewind = 1'b1;
        end
      end
      S_WB: if (mem_ack || mem_err) begin
        req_d = 1'b0; we_d = 1'b0; st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
    // Turning transmit off abandons the walk and rewinds the ring at once.
    if (!txen_q || dis_wr) begin
      st_d = S_IDLE; req_d = 1'b0; we_d = 1'b0; val_d = 1'b0; e_rewind = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= S_IDLE; req_q <= 1'b0; we_q <= 1'b0; addr_q <= RST_WORD;
      wdata_q <= RST_WORD; baddr_q <= RST_WORD; fw1_q <= RST_WORD; faddr_q <= RST_WORD;
      len_q <= 11'h000; last_q <= 1'b0; nocrc_q <= 1'b0; wrap_q <= 1'b0;
      first_q <= 1'b0; fidx_q <= 10'h000; byte_q <= 8'h00; val_q <= 1'b0;
      end_q <= 1'b0; crc_q <= 1'b0; pad_q <= 7'h00; bad_q <= 1'b0; errb_q <= 3'h0;
    end else begin
      st_q <= st_d; req_q <= req_d; we_q <= we_d; addr_q <= addr_d;
      wdata_q <= wdata_d; baddr_q <= baddr_d; fw1_q <= fw1_d; faddr_q <= faddr_d;
      len_q <= len_d; last_q <= last_d; nocrc_q <= nocrc_d; wrap_q <= wrap_d;
      first_q <= first_d; fidx_q <= fidx_d; byte_q <= byte_d; val_q <= val_d;
      end_q <= end_d; crc_q <= crc_d; pad_q <= pad_d; bad_q <= bad_d; errb_q <= errb_d;
    end
  end

  assign prdata     = rdata_q;
  assign pready     = rdy_q;
  assign pslverr    = serr_q;
  assign mem_req    = req_q;
  assign mem_we     = we_q;
  assign mem_addr   = addr_q;
  assign mem_wdata  = wdata_q;
  assign tx_byte    = byte_q;
  assign tx_valid   = val_q;
  assign tx_end     = end_q;
  assign tx_crc_en  = crc_q;
  assign tx_pad_len = pad_q;
  assign tx_bad     = bad_q;

  // ==========================================================================
  // Checks
  property p_qp_clears_go;
    @(posedge mclk) disable iff (rst) qp_wr |=> !go_q && idx == 10'h000;
  endproperty
  a_qp_clears_go: assert property (p_qp_clears_go) else $error("pointer write kept go");

  property p_dis_rewind;
    @(posedge mclk) disable iff (rst) dis_wr |=> !go_q && idx == 10'h000 && st_q == S_IDLE;
  endproperty
  a_dis_rewind: assert property (p_dis_rewind) else $error("disable did not rewind");

  property p_start_sets_go;
    @(posedge mclk) disable iff (rst)
    (start_wr && !halt_wr && !e_used_stop && !e_err_stop) |=> go_q;
  endproperty
  a_start_sets_go: assert property (p_start_sets_go) else $error("start missed");

  property p_halt_clears_go;
    @(posedge mclk) disable iff (rst) halt_wr |=> !go_q;
  endproperty
  a_halt_clears_go: assert property (p_halt_clears_go) else $error("halt kept go");

  property p_wb_used;
    @(posedge mclk) disable iff (rst)
    (st_q == S_WB && req_q) |-> mem_we && mem_wdata[D_USED] && mem_addr == faddr_q + W1_OFS;
  endproperty
  a_wb_used: assert property (p_wb_used) else $error("bad success write-back");

  property p_used_keeps_ptr;
    @(posedge mclk) disable iff (rst)
    (st_q == S_RD_W1 && mem_ack && !mem_err && mem_rdata[D_USED] && first_q && txen_q)
      |=> st_q == S_IDLE && !go_q && $stable(idx);
  endproperty
  a_used_keeps_ptr: assert property (p_used_keeps_ptr) else $error("used stop moved ptr");

  property p_err_rewind;
    @(posedge mclk) disable iff (rst)
    (st_q == S_ERR && req_q && we_q && mem_ack && txen_q) |=> idx == 10'h000 && !go_q;
  endproperty
  a_err_rewind: assert property (p_err_rewind) else $error("error kept pointer");

  property p_mid_used_err;
    @(posedge mclk) disable iff (rst)
    (st_q == S_RD_W1 && mem_ack && !mem_err && mem_rdata[D_USED] && !first_q && txen_q)
      |=> st_q == S_ERR ##1 tx_bad;
  endproperty
  a_mid_used_err: assert property (p_mid_used_err) else $error("mid-frame used not error");

  property p_collision_restart;
    @(posedge mclk) disable iff (rst)
    (st_q == S_WAIT && tx_collision && !tx_retry_limit && txen_q)
      |=> mem_addr == faddr_q + W1_OFS && idx == fidx_q;
  endproperty
  a_collision_restart: assert property (p_collision_restart) else $error("no replay");

  property p_pause_hold;
    @(posedge mclk) disable iff (rst)
    (st_q == S_IDLE && pen_q && pause_active) |=> st_q == S_IDLE;
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("frame started in pause");
endmodule : eth_tx_desc_dma
`default_nettype wire

/* verilog/tx_dma_pkg.sv */
// Shared constants for the transmit descriptor DMA block.
package tx_dma_pkg;
  // ==========================================================================
  // Register map (byte addresses) and fields
  localparam logic [7:0]  OFS_NCTRL    = 8'h00;
  localparam logic [7:0]  OFS_NCFG     = 8'h04;
  localparam logic [7:0]  OFS_TSTAT    = 8'h14;
  localparam logic [7:0]  OFS_TQPTR    = 8'h1C;
  localparam int          NC_TXEN      = 3;
  localparam int          NC_START     = 9;
  localparam int          NC_HALT      = 10;
  localparam int          CF_PAUSE_EN  = 13;
  localparam int          TS_RETRY     = 0;
  localparam int          TS_UNDER     = 1;
  localparam int          TS_EXH       = 2;
  localparam int          TS_GO        = 3;
  localparam int          TS_USED      = 4;
  // ==========================================================================
  // Descriptor word one fields
  localparam int          D_USED       = 31;
  localparam int          D_WRAP       = 30;
  localparam int          D_RETRY      = 29;
  localparam int          D_UNDER      = 28;
  localparam int          D_EXH        = 27;
  localparam int          D_NOCRC      = 16;
  localparam int          D_LAST       = 15;
  localparam int          D_LEN_MSB    = 10;
  localparam logic [31:0] DESC_BYTES   = 32'h0000_0008;
  localparam logic [31:0] W1_OFS       = 32'h0000_0004;
  // ==========================================================================
  // Counts
  localparam int          RING_MAX     = 1024;
  localparam int          MAX_BUFS     = 128;
  localparam int          MIN_FRAME    = 64;
  localparam int          CRC_BYTES    = 4;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
endpackage : tx_dma_pkg

/* verilog/tx_pad_count.sv */
// Counts frame bytes and derives the pad needed before the appended CRC.
`timescale 1ns/1ns
`default_nettype none
module tx_pad_count
  import tx_dma_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic       inc,
  output logic      [6:0] pad_len
);
  localparam logic [15:0] BODY_MIN = 16'(MIN_FRAME - CRC_BYTES);
  logic [15:0] cnt_q, cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (clr) cnt_d = 16'h0000;
    else if (inc && cnt_q != 16'hFFFF) cnt_d = cnt_q + 16'h0001;
  end

  always_ff @(posedge mclk) begin
    if (rst) cnt_q <= 16'h0000;
    else cnt_q <= cnt_d;
  end

  // Body plus pad plus CRC reaches the minimum frame length.
  assign pad_len = (cnt_q < BODY_MIN) ? 7'(BODY_MIN - cnt_q) : 7'h00;

  property p_pad_min;
    @(posedge mclk) disable iff (rst)
    (cnt_q < BODY_MIN) |-> (16'(pad_len) + cnt_q == BODY_MIN);
  endproperty
  a_pad_min: assert property (p_pad_min) else $error("pad misses minimum");
endmodule : tx_pad_count
`default_nettype wire

/* verilog/tx_ring_ptr.sv */
// Descriptor ring pointer with wrap flag and fixed ring length rollover.
`timescale 1ns/1ns
`default_nettype none
module tx_ring_ptr
  import tx_dma_pkg::*;
#(
  parameter int unsigned RING_LEN = RING_MAX
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [31:0] base_in,
  input  wire logic        rewind,
  input  wire logic        restart,
  input  wire logic [9:0]  restart_idx,
  input  wire logic        advance,
  input  wire logic        wrap,
  output logic      [9:0]  idx,
  output logic      [31:0] desc_addr
);
  logic [31:0] base_q, base_d;
  logic [9:0]  idx_q, idx_d;

  always_comb begin
    base_d = base_q;
    idx_d  = idx_q;
    if (load) begin
      base_d = base_in;
      idx_d  = 10'h000;
    end else if (rewind) begin
      idx_d = 10'h000;
    end else if (restart) begin
      idx_d = restart_idx;
    end else if (advance) begin
      // A ring with no wrap flag still closes after the last slot.
      if (wrap || idx_q == 10'(RING_LEN - 1)) idx_d = 10'h000;
      else idx_d = idx_q + 10'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      base_q <= RST_WORD;
      idx_q  <= 10'h000;
    end else begin
      base_q <= base_d;
      idx_q  <= idx_d;
    end
  end

  assign idx       = idx_q;
  assign desc_addr = base_q + {19'h00000, idx_q, 3'h0};

  property p_wrap_roll;
    @(posedge mclk) disable iff (rst)
    (advance && !load && !rewind && !restart && (wrap || idx_q == 10'(RING_LEN - 1)))
      |=> idx_q == 10'h000;
  endproperty
  a_wrap_roll: assert property (p_wrap_roll) else $error("ring did not roll over");
endmodule : tx_ring_ptr
`default_nettype wire
